//--- hw/plse_comparator.sv
// Comparator A: absolute monitored value against a percent threshold.
// Assumes full scale of the monitored value is 32767.
`timescale 1ns/100ps
`include "plse_consts.svh"
module plse_comparator
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Monitored value and threshold in percent.
    input wire logic signed [15:0] value,
    input wire logic [7:0] threshold,
    // Registered result.
    output logic above
);
    logic above_r;
    wire [15:0] abs_v = value[15] ? 16'(-value) : 16'(value);
    wire [23:0] lhs = 24'(abs_v) * `PLSE_PCT_100;
    wire [23:0] rhs = 24'(threshold) * `PLSE_FULL_SCALE;
    wire above_nxt = lhs > rhs;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            above_r <= 1'b0;
        else
            above_r <= above_nxt;
    assign above = above_r;

    property p_cmp_abs;
        @(posedge core_clk) disable iff (rst)
        (value == -$past(value) && $stable(threshold) && value != 16'h8000)
        |=> (above_r == $past(above_r, 1));
    endproperty
    a_cmp_abs: assert property (p_cmp_abs) else $error("abs");
endmodule

//--- hw/plse_consts.svh
// Constants of the programmable statement logic engine.
// Assumes a 200 MHz core clock and 32-bit register words.
`ifndef PLSE_CONSTS_SVH
`define PLSE_CONSTS_SVH
`define PLSE_A_MODE 8'h00
`define PLSE_A_OUT1 8'h04
`define PLSE_A_CSRC 8'h08
`define PLSE_A_CTHR 8'h0C
`define PLSE_A_TPRE 8'h10
`define PLSE_A_STAT 8'h14
`define PLSE_A_SLOT0 8'h40
`define PLSE_MODE_PLC 8'h01
`define PLSE_OUT1_PLC 8'h01
`define PLSE_RST_PRESET 16'h012C
`define PLSE_FULL_SCALE 24'h007FFF
`define PLSE_PCT_100 24'h000064
`define PLSE_SCAN_MS 10
`define PLSE_CLK_KHZ 200000
`define PLSE_C_FALSE 8'h00
`define PLSE_C_TRUE 8'h01
`define PLSE_C_DIN1 8'h32
`define PLSE_C_DIN8 8'h39
`define PLSE_C_CMPA 8'h4C
`define PLSE_C_TMRA 8'h56
`define PLSE_C_VARA 8'h64
`define PLSE_C_VARD 8'h67
`define PLSE_A_JOGREV 8'h05
`define PLSE_A_JOGFWD 8'h06
`define PLSE_A_JOGEN 8'h12
`define PLSE_A_FAULT 8'h13
`define PLSE_A_RUNFWD 8'h14
`define PLSE_A_RUNREV 8'h15
`define PLSE_A_FRESET 8'h17
`define PLSE_A_PID 8'h1D
`define PLSE_A_DOUT1 8'h1F
`define PLSE_A_TBLEN 8'h22
`define PLSE_A_TBLB0 8'h23
`define PLSE_A_TBLB1 8'h24
`define PLSE_A_SPEED 8'h26
`define PLSE_A_VARA 8'h28
`define PLSE_A_VARD 8'h2B
`define PLSE_A_TSTART 8'h32
`define PLSE_O_FWD 0
`define PLSE_O_REV 1
`define PLSE_O_JEN 2
`define PLSE_O_JFW 3
`define PLSE_O_JRV 4
`define PLSE_O_FRS 5
`define PLSE_O_FLT 6
`define PLSE_O_PID 7
`define PLSE_O_SPD 8
`define PLSE_O_TSE 9
`define PLSE_O_TB0 10
`define PLSE_O_TB1 11
`define PLSE_O_DO1 12
`define PLSE_NOUT 13
`endif

//--- hw/plse_engine.sv
// Statement logic engine: slot store, ordered scan, actions and registers.
// Assumes synchronous terminal inputs and a one-cycle-latency register port.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
`include "plse_consts.svh"
module plse_engine #(
    parameter int NSLOT = 16,
    parameter int SCAN_CYCLES = `PLSE_SCAN_MS * `PLSE_CLK_KHZ
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Terminal inputs and monitored values.
    input wire logic [7:0] din,
    input wire logic signed [15:0] mon0,
    input wire logic signed [15:0] mon1,
    input wire logic signed [15:0] mon2,
    input wire logic signed [15:0] mon3,
    // Drive commands.
    output logic run_fwd,
    output logic run_rev,
    output logic jog_en,
    output logic jog_fwd,
    output logic jog_rev,
    output logic fault_reset,
    output logic fault,
    output logic pid_en,
    output logic speed_mode,
    output logic table_sel_en,
    output logic [1:0] table_idx,
    output logic dout1,
    output logic scan_busy
);
    localparam int SW = $clog2(NSLOT);
    localparam logic [SW-1:0] LAST = SW'(NSLOT - 1);

    plse_pkg::plse_state_t state_r, state_nxt;
    logic [31:0] slot_mem [NSLOT];
    logic [7:0] mode_r, out1_r, csrc_r, cthr_r;
    logic [15:0] tpre_r;
    logic [SW-1:0] slot_r;
    logic [3:0] vars_r;
    logic [`PLSE_NOUT-1:0] sh_r, out_r;
    logic [31:0] tick_cnt_r, rdata_r;
    logic busy_r, tick_r;
    logic cmp_a, tmr_a;
    logic [15:0] tmr_cnt;

    // Periodic scan tick; one divider serves scan and timer alike.
    wire tick_wrap = tick_cnt_r == 32'(SCAN_CYCLES - 1);
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + 1'b1;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            tick_r <= 1'b0;
        else
            tick_r <= tick_wrap;

    // Statement decode.
    wire [31:0] stm = slot_mem[slot_r];
    wire [7:0] code_a = stm[31:24];
    wire [7:0] op = stm[23:16];
    wire [7:0] code_b = stm[15:8];
    wire [7:0] act = stm[7:0];

    // Every source is an argument, so the assignments below re-evaluate
    // when an input changes even while the slot word stays the same.
    function automatic logic cond(input logic [7:0] c, input logic [7:0] d,
        input logic cm, input logic tm, input logic [3:0] vr);
        logic v;
        v = 1'b0;
        if (c == `PLSE_C_TRUE)
            v = 1'b1;
        else if (c >= `PLSE_C_DIN1 && c <= `PLSE_C_DIN8)
            v = d[3'(c - `PLSE_C_DIN1)];
        else if (c == `PLSE_C_CMPA)
            v = cm;
        else if (c == `PLSE_C_TMRA)
            v = tm;
        else if (c >= `PLSE_C_VARA && c <= `PLSE_C_VARD)
            v = vr[2'(c - `PLSE_C_VARA)];
        return v;
    endfunction

    wire ca = cond(code_a, din, cmp_a, tmr_a, vars_r);
    wire cb = cond(code_b, din, cmp_a, tmr_a, vars_r);
    // Unknown operators yield false so a corrupt word drives its action off.
    wire res = (op == plse_pkg::PLSE_OR) ? (ca | cb) :
               (op == plse_pkg::PLSE_AND) ? (ca & cb) :
               (op == plse_pkg::PLSE_XOR) ? (ca ^ cb) :
               (op == plse_pkg::PLSE_NOR) ? ~(ca | cb) : 1'b0;
    wire scanning = state_r == plse_pkg::PLSE_SCAN;
    wire plc_mode = mode_r == `PLSE_MODE_PLC;
    wire var_act = act >= `PLSE_A_VARA && act <= `PLSE_A_VARD;
    wire [1:0] var_sel = 2'(act - `PLSE_A_VARA);
    wire tmr_clr = scanning && act == `PLSE_A_TSTART && res;

    // Action code to command bit; last statement naming a command wins.
    logic [`PLSE_NOUT-1:0] act_hit;
    always_comb
    begin
        act_hit = '0;
        case (act)
            `PLSE_A_RUNFWD: act_hit[`PLSE_O_FWD] = 1'b1;
            `PLSE_A_RUNREV: act_hit[`PLSE_O_REV] = 1'b1;
            `PLSE_A_JOGEN: act_hit[`PLSE_O_JEN] = 1'b1;
            `PLSE_A_JOGFWD: act_hit[`PLSE_O_JFW] = 1'b1;
            `PLSE_A_JOGREV: act_hit[`PLSE_O_JRV] = 1'b1;
            `PLSE_A_FRESET: act_hit[`PLSE_O_FRS] = 1'b1;
            `PLSE_A_FAULT: act_hit[`PLSE_O_FLT] = 1'b1;
            `PLSE_A_PID: act_hit[`PLSE_O_PID] = 1'b1;
            `PLSE_A_SPEED: act_hit[`PLSE_O_SPD] = 1'b1;
            `PLSE_A_TBLEN: act_hit[`PLSE_O_TSE] = 1'b1;
            `PLSE_A_TBLB0: act_hit[`PLSE_O_TB0] = 1'b1;
            `PLSE_A_TBLB1: act_hit[`PLSE_O_TB1] = 1'b1;
            `PLSE_A_DOUT1: act_hit[`PLSE_O_DO1] = 1'b1;
            default: act_hit = '0;
        endcase
    end

    // Scan sequencer.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            plse_pkg::PLSE_IDLE:
                if (tick_r && plc_mode)
                    state_nxt = plse_pkg::PLSE_SCAN;
            plse_pkg::PLSE_SCAN:
                if (slot_r == LAST)
                    state_nxt = plse_pkg::PLSE_DONE;
            plse_pkg::PLSE_DONE:
                state_nxt = plse_pkg::PLSE_IDLE;
            default:
                state_nxt = plse_pkg::PLSE_IDLE;
        endcase
    end
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            state_r <= plse_pkg::PLSE_IDLE;
        else
            state_r <= state_nxt;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            slot_r <= '0;
        else if (scanning)
            slot_r <= (slot_r == LAST) ? '0 : slot_r + 1'b1;

    // Variables update at once so later slots of this scan see them.
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            vars_r <= '0;
        else if (scanning && var_act)
            vars_r[var_sel] <= res;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            sh_r <= '0;
        else if (state_r == plse_pkg::PLSE_IDLE && tick_r)
            sh_r <= '0;
        else if (scanning)
            sh_r <= (sh_r & ~act_hit) | (act_hit & {`PLSE_NOUT{res}});

    // Commands change only between scans, or clear at once when PLC mode is off, so a scan never glitches them.
    wire [`PLSE_NOUT-1:0] out_nxt = plc_mode ? sh_r : '0;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            out_r <= '0;
        else if (state_r == plse_pkg::PLSE_DONE || !plc_mode)
            out_r <= out_nxt;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            busy_r <= 1'b0;
        else
            busy_r <= state_nxt != plse_pkg::PLSE_IDLE;
    wire do1_nxt = out_r[`PLSE_O_DO1] && out1_r == `PLSE_OUT1_PLC;
    logic do1_r;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            do1_r <= 1'b0;
        else
            do1_r <= do1_nxt;

    assign run_fwd = out_r[`PLSE_O_FWD];
    assign run_rev = out_r[`PLSE_O_REV];
    assign jog_en = out_r[`PLSE_O_JEN];
    assign jog_fwd = out_r[`PLSE_O_JFW];
    assign jog_rev = out_r[`PLSE_O_JRV];
    assign fault_reset = out_r[`PLSE_O_FRS];
    assign fault = out_r[`PLSE_O_FLT];
    assign pid_en = out_r[`PLSE_O_PID];
    assign speed_mode = out_r[`PLSE_O_SPD];
    assign table_sel_en = out_r[`PLSE_O_TSE];
    assign table_idx = {out_r[`PLSE_O_TB1], out_r[`PLSE_O_TB0]};
    assign dout1 = do1_r;
    assign scan_busy = busy_r;

    // Comparator and timer.
    wire signed [15:0] mon_sel = (csrc_r[1:0] == 2'h0) ? mon0 :
                                 (csrc_r[1:0] == 2'h1) ? mon1 :
                                 (csrc_r[1:0] == 2'h2) ? mon2 : mon3;
    plse_comparator u_cmp (
        .core_clk(core_clk),
        .rst(rst),
        .value(mon_sel),
        .threshold(cthr_r),
        .above(cmp_a)
    );
    plse_timer #(.W(16)) u_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick_r),
        .clr(tmr_clr),
        .preset(tpre_r),
        .count(tmr_cnt),
        .expired(tmr_a)
    );

    // Register port.
    wire wr_mode = reg_wr && reg_addr == `PLSE_A_MODE;
    wire wr_out1 = reg_wr && reg_addr == `PLSE_A_OUT1;
    wire wr_csrc = reg_wr && reg_addr == `PLSE_A_CSRC;
    wire wr_cthr = reg_wr && reg_addr == `PLSE_A_CTHR;
    wire wr_tpre = reg_wr && reg_addr == `PLSE_A_TPRE;
    wire slot_hit = reg_addr[7:6] == `PLSE_A_SLOT0 >> 6
                    && 32'(reg_addr[5:2]) < NSLOT;
    wire [SW-1:0] slot_wa = SW'(reg_addr[5:2]);
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            mode_r <= '0;
            out1_r <= '0;
            csrc_r <= '0;
            cthr_r <= '0;
            tpre_r <= `PLSE_RST_PRESET;
        end
        else
        begin
            if (wr_mode)
                mode_r <= reg_wdata[7:0];
            if (wr_out1)
                out1_r <= reg_wdata[7:0];
            if (wr_csrc)
                csrc_r <= reg_wdata[7:0];
            if (wr_cthr)
                cthr_r <= reg_wdata[7:0];
            if (wr_tpre)
                tpre_r <= reg_wdata[15:0];
        end
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            for (int i = 0; i < NSLOT; i++)
                slot_mem[i] <= '0;
        else if (reg_wr && slot_hit)
            slot_mem[slot_wa] <= reg_wdata;
    wire [31:0] stat = {3'h0, busy_r, tmr_cnt, vars_r, 8'h00}
                       | {19'h0, out_r};
    wire [31:0] rd_mux =
        (reg_addr == `PLSE_A_MODE) ? {24'h0, mode_r} :
        (reg_addr == `PLSE_A_OUT1) ? {24'h0, out1_r} :
        (reg_addr == `PLSE_A_CSRC) ? {24'h0, csrc_r} :
        (reg_addr == `PLSE_A_CTHR) ? {24'h0, cthr_r} :
        (reg_addr == `PLSE_A_TPRE) ? {16'h0, tpre_r} :
        (reg_addr == `PLSE_A_STAT) ? stat :
        slot_hit ? slot_mem[slot_wa] : 32'h0;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            rdata_r <= '0;
        else
            rdata_r <= reg_rd ? rd_mux : 32'h0;
    assign reg_rdata = rdata_r;

    // Checks.
    property p_mode_gate;
        @(posedge core_clk) disable iff (rst)
        (state_r == plse_pkg::PLSE_IDLE && !plc_mode) |=>
            state_r == plse_pkg::PLSE_IDLE;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("mode");
    property p_order;
        @(posedge core_clk) disable iff (rst)
        (scanning && slot_r != LAST) |=> slot_r == $past(slot_r) + 1'b1;
    endproperty
    a_order: assert property (p_order) else $error("slot order");
    property p_xor;
        @(posedge core_clk) disable iff (rst)
        (op == plse_pkg::PLSE_XOR) |-> res == (ca != cb);
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");
    property p_nor;
        @(posedge core_clk) disable iff (rst)
        (op == plse_pkg::PLSE_NOR && code_a == `PLSE_C_DIN8
         && code_b == `PLSE_C_FALSE) |-> res == !din[7];
    endproperty
    a_nor: assert property (p_nor) else $error("nor wrong");
    property p_true;
        @(posedge core_clk) disable iff (rst)
        (code_a == `PLSE_C_TRUE && op == plse_pkg::PLSE_OR) |-> res;
    endproperty
    a_true: assert property (p_true) else $error("true code");
    property p_var;
        @(posedge core_clk) disable iff (rst)
        (scanning && act == `PLSE_A_VARA) |=> vars_r[0] == $past(res);
    endproperty
    a_var: assert property (p_var) else $error("var A");
    sequence s_scan_end;
        state_r == plse_pkg::PLSE_DONE && plc_mode;
    endsequence
    property p_latch;
        @(posedge core_clk) disable iff (rst)
        s_scan_end |=> out_r == $past(sh_r);
    endproperty
    a_latch: assert property (p_latch) else $error("latch");
    property p_scan_len;
        @(posedge core_clk) disable iff (rst)
        (state_r == plse_pkg::PLSE_IDLE && tick_r && plc_mode) |=>
            scanning ##(NSLOT) state_r == plse_pkg::PLSE_DONE;
    endproperty
    a_scan_len: assert property (p_scan_len) else $error("len");
    property p_tclr;
        @(posedge core_clk) disable iff (rst)
        (scanning && act == `PLSE_A_TSTART && res) |=> tmr_cnt == 16'h0000;
    endproperty
    a_tclr: assert property (p_tclr) else $error("timer clr");
endmodule

//--- hw/plse_pkg.sv
// Types of the programmable statement logic engine.
// Assumes the constants header is included by the design files.
package plse_pkg;
    typedef enum logic [1:0] {
        PLSE_IDLE = 2'h0,
        PLSE_SCAN = 2'h1,
        PLSE_DONE = 2'h3
    } plse_state_t;
    typedef enum logic [7:0] {
        PLSE_OR = 8'h00,
        PLSE_AND = 8'h01,
        PLSE_XOR = 8'h02,
        PLSE_NOR = 8'h03
    } plse_op_t;
endpackage

//--- hw/plse_timer.sv
// Delay timer A counting hundredths of a second on the scan tick.
// Assumes one tick per hundredth; the count saturates at its maximum.
`timescale 1ns/100ps
`include "plse_consts.svh"
module plse_timer #(
    parameter int W = 16
)
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Control.
    input wire logic tick,
    input wire logic clr,
    input wire logic [W-1:0] preset,
    // State.
    output logic [W-1:0] count,
    output logic expired
);
    logic [W-1:0] cnt_r;
    wire sat = &cnt_r;
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
            cnt_r <= '0;
        else if (clr)
            cnt_r <= '0;
        else if (tick && !sat)
            cnt_r <= cnt_r + 1'b1;
    assign count = cnt_r;
    assign expired = cnt_r >= preset;

    property p_clr_zero;
        @(posedge core_clk) disable iff (rst)
        clr |=> cnt_r == '0;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("clear");
    property p_hold;
        @(posedge core_clk) disable iff (rst)
        (!clr && !tick) |=> $stable(cnt_r);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved");
endmodule

//--- verification/plse_terminal_model.sv
// Model of the drive terminal strip and the monitored drive values.
// Assumes the bench sets the wanted levels; they reach the pins a cycle later.
`timescale 1ns/100ps
module plse_terminal_model
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Levels wanted by the bench.
    input wire logic [7:0] want_din,
    input wire logic signed [15:0] want_mon,
    // Terminal inputs and monitors.
    output logic [7:0] din,
    output logic signed [15:0] mon0,
    output logic signed [15:0] mon1,
    output logic signed [15:0] mon2,
    output logic signed [15:0] mon3
);
    logic [15:0] spin_r;
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            spin_r <= 16'h0000;
            din <= 8'h00;
            mon0 <= 16'h0000;
        end
        else
        begin
            spin_r <= spin_r + 16'h1357;
            din <= want_din;
            mon0 <= want_mon;
        end
    end
    // Unselected monitors churn every cycle, so a wrong source pick shows.
    assign mon1 = spin_r;
    assign mon2 = ~spin_r;
    assign mon3 = {spin_r[7:0], spin_r[15:8]};
endmodule

//--- verification/test_plc_statement_logic_engine.sv
// Self-checking bench for the statement logic engine.
// Assumes a short scan period; the terminal model drives inputs and monitors.
`timescale 1ns/100ps
`include "plse_consts.svh"
module test_plc_statement_logic_engine;
    localparam int SC = 40;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] want_din = 8'h80;
    logic signed [15:0] want_mon = 16'h0000;
    logic [7:0] din;
    logic signed [15:0] mon0, mon1, mon2, mon3;
    logic run_fwd, run_rev, jog_en, jog_fwd, jog_rev, fault_reset, fault;
    logic pid_en, speed_mode, table_sel_en, dout1, scan_busy;
    logic [1:0] table_idx;
    logic [12:0] seen;
    logic [31:0] rd;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] prog [16] = '{32'h4C000028, 32'h32000014, 32'h33000015,
        32'h64000026, 32'h3502641D, 32'h36003712, 32'h36000006, 32'h37000005,
        32'h38000017, 32'h39000032, 32'h56000013, 32'h01000022, 32'h34000023,
        32'h34013524, 32'h6400001F, 32'h3903002B};
    logic [15:0] corner [4] = '{16'h1999, 16'h199A, 16'hE666, 16'hE667};

    always #2.5 core_clk = ~core_clk;

    assign seen = {dout1, table_idx[1], table_idx[0], table_sel_en, speed_mode,
        pid_en, fault, fault_reset, jog_rev, jog_fwd, jog_en, run_rev, run_fwd};

    plse_terminal_model u_plse_terminal_model (.core_clk(core_clk), .rst(rst),
        .want_din(want_din), .want_mon(want_mon), .din(din), .mon0(mon0),
        .mon1(mon1), .mon2(mon2), .mon3(mon3));

    plse_engine #(.NSLOT(16), .SCAN_CYCLES(SC)) u_plse_engine (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .din(din), .mon0(mon0), .mon1(mon1),
        .mon2(mon2), .mon3(mon3), .run_fwd(run_fwd), .run_rev(run_rev),
        .jog_en(jog_en), .jog_fwd(jog_fwd), .jog_rev(jog_rev),
        .fault_reset(fault_reset), .fault(fault), .pid_en(pid_en),
        .speed_mode(speed_mode), .table_sel_en(table_sel_en),
        .table_idx(table_idx), .dout1(dout1), .scan_busy(scan_busy));

    // Commands the loaded program must give; the comparator threshold is 20.
    function automatic logic [12:0] expect_cmds(input logic [7:0] d,
        input logic [15:0] m, input logic flt, input logic src);
        logic [15:0] mag;
        logic a;
        logic [12:0] e;
        mag = m[15] ? 16'(-m) : m;
        a = (32'(mag) * 32'h00000064) > (32'h00000014 * 32'h00007FFF);
        e = {src & a, d[2] & d[3], d[2], 1'b1, a, d[3] ^ a, flt, d[6],
            d[5], d[4], d[4] | d[5], d[1], d[0]};
        return e;
    endfunction

    task automatic check(input string what, input logic [31:0] got,
        input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic set_terms(input logic [7:0] d, input logic [15:0] m);
        @(posedge core_clk);
        want_din <= d;
        want_mon <= m;
    endtask

    // Waits for k scans to finish, a scan already running at entry counting as the first, each bounded.
    task automatic wait_scans(input int k);
        int n;
        repeat (k)
        begin
            n = 0;
            while (scan_busy !== 1'b1 && n < 4 * SC)
            begin
                @(posedge core_clk);
                n++;
            end
            while (scan_busy !== 1'b0 && n < 4 * SC)
            begin
                @(posedge core_clk);
                n++;
            end
            if (n >= 4 * SC)
            begin
                fails++;
                $display("MISMATCH scan_done expected 1 seen 0");
                complete_run();
            end
        end
        @(negedge core_clk);
    endtask

    // Counts busy cycles over three whole scan periods.
    task automatic count_scans(output logic [31:0] starts);
        starts = 32'h00000000;
        repeat (3 * SC)
        begin
            @(negedge core_clk);
            if (scan_busy !== 1'b0)
                starts = starts + 32'h00000001;
        end
    endtask

    initial
    begin
        logic [7:0] d;
        logic [15:0] m;
        logic [12:0] e;
        void'($urandom(32'h43A2B807));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("reset_cmds", 32'(seen), 32'h00000000);
        count_scans(rd);
        check("idle_scans", rd, 32'h00000000);
        reg_read(`PLSE_A_TPRE, rd);
        check("preset_reset", rd, 32'h0000012C);
        reg_read(8'hFC, rd);
        check("unmapped", rd, 32'h00000000);
        for (int i = 0; i < 16; i++)
            reg_write(`PLSE_A_SLOT0 + 8'(4 * i), prog[i]);
        reg_read(`PLSE_A_SLOT0 + 8'h10, rd);
        check("slot4", rd, prog[4]);
        reg_write(`PLSE_A_CSRC, 32'h00000000);
        reg_write(`PLSE_A_CTHR, 32'h00000014);
        reg_write(`PLSE_A_TPRE, 32'h00000004);
        reg_write(`PLSE_A_OUT1, 32'(`PLSE_OUT1_PLC));
        reg_write(`PLSE_A_MODE, 32'(`PLSE_MODE_PLC));
        reg_read(`PLSE_A_TPRE, rd);
        check("preset", rd, 32'h00000004);
        wait_scans(2);
        // Each period of 40 cycles holds one scan of NSLOT + 1 busy cycles.
        count_scans(rd);
        check("busy_len", rd, 32'h00000033);
        wait_scans(1);
        // Boundary magnitudes first, then random terminals and speeds.
        for (int i = 0; i < 40; i++)
        begin
            d = 8'($urandom) | 8'h80;
            m = (i < 4) ? corner[i] : 16'($urandom);
            if (m == 16'h8000)
                m = 16'h8001;
            set_terms(d, m);
            wait_scans(1);
            e = expect_cmds(d, m, 1'b0, 1'b1);
            check("cmds", 32'(seen), 32'(e));
            check("jog", 32'(seen[4:2]), 32'(e[4:2]));
            check("pid", 32'(seen[7]), 32'(e[7]));
            check("speed", 32'(seen[8]), 32'(e[8]));
            check("table", 32'(seen[11:9]), 32'(e[11:9]));
            check("dout1", 32'(seen[12]), 32'(e[12]));
        end
        // A short drop of input 8 must not let timer A expire.
        set_terms(8'h00, 16'h0000);
        wait_scans(2);
        e = expect_cmds(8'h00, 16'h0000, 1'b0, 1'b1);
        check("short_drop", 32'(seen), 32'(e));
        set_terms(8'h80, 16'h0000);
        wait_scans(2);
        e = expect_cmds(8'h80, 16'h0000, 1'b0, 1'b1);
        check("restart", 32'(seen), 32'(e));
        set_terms(8'h00, 16'h0000);
        wait_scans(8);
        e = expect_cmds(8'h00, 16'h0000, 1'b1, 1'b1);
        check("timeout", 32'(seen), 32'(e));
        // Eight ticks since the last clear; variable D is input 8 NOR false.
        reg_read(`PLSE_A_STAT, rd);
        check("status", rd, 32'h00008A40);
        set_terms(8'h80, 16'h0000);
        wait_scans(2);
        e = expect_cmds(8'h80, 16'h0000, 1'b0, 1'b1);
        check("cleared", 32'(seen), 32'(e));
        // Output 1 handed to another source stays off even with A set.
        reg_write(`PLSE_A_OUT1, 32'h00000000);
        set_terms(8'h80, 16'h7FFF);
        wait_scans(2);
        e = expect_cmds(8'h80, 16'h7FFF, 1'b0, 1'b0);
        check("out1_src", 32'(seen), 32'(e));
        reg_write(`PLSE_A_MODE, 32'h00000000);
        repeat (3) @(negedge core_clk);
        check("mode_off", 32'(seen), 32'h00000000);
        count_scans(rd);
        check("off_scans", rd, 32'h00000000);
        complete_run();
    end
endmodule
